// ==== rtl/ucrd_pkg.sv ====
// package for the usb control request decoder
// assumes an upstream protocol engine delivers 8-byte setup packets already checked
package ucrd_pkg;
  // request types
  localparam logic [7:0] RT_STD_DEV_OUT = 8'h00;
  localparam logic [7:0] RT_STD_IF_OUT = 8'h01;
  localparam logic [7:0] RT_STD_EP_OUT = 8'h02;
  localparam logic [7:0] RT_STD_DEV_IN = 8'h80;
  localparam logic [7:0] RT_STD_IF_IN = 8'h81;
  localparam logic [7:0] RT_STD_EP_IN = 8'h82;
  localparam logic [7:0] RT_VND_OUT = 8'h40;
  localparam logic [7:0] RT_VND_IN = 8'hc0;
  // request codes
  localparam logic [7:0] RQ_GET_STATUS = 8'h00;
  localparam logic [7:0] RQ_CLR_FEATURE = 8'h01;
  localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
  localparam logic [7:0] RQ_SET_ADDRESS = 8'h05;
  localparam logic [7:0] RQ_GET_DESC = 8'h06;
  localparam logic [7:0] RQ_GET_CONFIG = 8'h08;
  localparam logic [7:0] RQ_SET_CONFIG = 8'h09;
  localparam logic [7:0] RQ_GET_IFACE = 8'h0a;
  localparam logic [7:0] RQ_SET_IFACE = 8'h0b;
  localparam logic [7:0] RQ_REG_WRITE = 8'ha0;
  localparam logic [7:0] RQ_REG_READ = 8'ha1;
  localparam logic [7:0] RQ_GET_STATS = 8'ha2;
  // feature selectors
  localparam logic [15:0] FS_EP_HALT = 16'h0000;
  localparam logic [15:0] FS_REMOTE_WAKE = 16'h0001;
  localparam logic [15:0] FS_TEST_MODE = 16'h0002;
  // descriptor types (high byte of value)
  localparam logic [7:0] DT_DEVICE = 8'h01;
  localparam logic [7:0] DT_CONFIG = 8'h02;
  localparam logic [7:0] DT_STRING = 8'h03;
  localparam logic [7:0] DT_QUALIFIER = 8'h06;
  localparam logic [7:0] DT_OTHER_SPEED = 8'h07;
  // endpoint indices for status
  localparam logic [15:0] EP_BULK_IN = 16'h0081;
  localparam logic [15:0] EP_BULK_OUT = 16'h0002;
  localparam logic [15:0] EP_INTR_IN = 16'h0083;
  localparam logic [15:0] EP_MAX_NUM = 16'h0003;
  localparam logic [15:0] EP_NUM_MASK = 16'h000f;
  // lengths and fixed values
  localparam logic [15:0] LEN_ZERO = 16'h0000;
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_TWO = 16'h0002;
  localparam logic [15:0] LEN_WORD = 16'h0004;
  localparam logic [15:0] LEN_RX_STATS = 16'h0020;
  localparam logic [15:0] LEN_TX_STATS = 16'h0028;
  localparam logic [15:0] IDX_RX_STATS = 16'h0000;
  localparam logic [15:0] IDX_TX_STATS = 16'h0001;
  localparam logic [7:0] CONFIG_VALUE = 8'h01;
  localparam logic [3:0] IDX_UPPER_ZERO = 4'h0;
  localparam int NUM_EP = 4;
  localparam int RX_WORDS = 8;
  localparam int TX_WORDS = 10;
  // answer kinds
  typedef enum logic [3:0] {
    UCRD_ACK_NODATA = 4'b0000,
    UCRD_RESP_BYTES = 4'b0001,
    UCRD_DESC_FETCH = 4'b0010,
    UCRD_REG_WRITE = 4'b0011,
    UCRD_REG_READ = 4'b0100,
    UCRD_STATS = 4'b0101,
    UCRD_STALL = 4'b0110
  } ucrd_answer_e;
  // fsm
  typedef enum logic [1:0] {
    UCRD_IDLE = 2'b00,
    UCRD_WDATA = 2'b01,
    UCRD_STREAM = 2'b10
  } ucrd_state_e;
endpackage

// ==== rtl/ucrd_decoder.sv ====
// control endpoint setup decoder with standard and vendor request handling
// assumes setup fields arrive as one pulse; data stages flow word by word to and from the engine
//
// Contract
// RL1 - clear feature: device clears remote wakeup, endpoint clears halt
// RL2 - endpoint clear feature uses index to pick endpoint zero to three
// RL3 - get configuration answers one byte with current configuration value
// RL4 - get descriptor fetches selected descriptor, truncated to requested length
// RL5 - interface or endpoint descriptor requests are stalled
// RL6 - get interface answers one byte holding alternate setting
// RL7 - device status: self powered bit 0, remote wakeup bit 1
// RL8 - endpoint status: halt in bit 0, for endpoints 81h, 02h, 83h
// RL9 - set address adopts device address from value field
// RL10 - set feature sets halt, remote wakeup or test mode by selector
// RL11 - set configuration moves device into configured state
// RL12 - host uses configuration value 01h only
// RL13 - set interface acked only for alternate and interface both zero
// RL14 - mac register accesses stalled while in normal power state
// RL15 - register write: 40h, A0h, zero value, length 4, 12-bit address
// RL16 - register write moves exactly one 32-bit word, no bursts
// RL17 - register read: C0h, A1h, length 4, one 32-bit word back
// RL18 - statistics request returns whole rx or tx store by index
// RL19 - original variant clears store after serving, counters saturate
// RL20 - later variant snapshots counters, no clear, counters wrap
// RL21 - statistics: C0h, A2h, index 0 rx length 20h, index 1 tx 28h
// RL22 - any unmatched setup packet is stalled
`timescale 1ns/1ns
module ucrd_decoder #(
  parameter bit SnapshotVariant = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic setupValid,
  input wire logic [7:0] setupType,
  input wire logic [7:0] setupRequest,
  input wire logic [15:0] setupValue,
  input wire logic [15:0] setupIndex,
  input wire logic [15:0] setupLength,
  input wire logic selfPowered,
  input wire logic normalPowerState,
  input wire logic [11:0] macSpaceBase,
  input wire logic outWordValid,
  input wire logic [31:0] outWord,
  input wire logic inWordReady,
  input wire logic [31:0] regReadData,
  input wire logic [31:0] rxStatsWord,
  input wire logic [31:0] txStatsWord,
  output logic answerValid,
  output ucrd_pkg::ucrd_answer_e answerKind,
  output logic [15:0] respBytes,
  output logic [15:0] respLength,
  output logic descFetch,
  output logic [7:0] descType,
  output logic [7:0] descIndex,
  output logic [15:0] descLength,
  output logic regWrite,
  output logic regRead,
  output logic [11:0] regAddr,
  output logic [31:0] regWriteData,
  output logic inWordValid,
  output logic [31:0] inWord,
  output logic [3:0] statsIndex,
  output logic statsSelTx,
  output logic statsClear,
  output logic statsSnapshot,
  output logic [6:0] deviceAddress,
  output logic configured,
  output logic remoteWakeEnable,
  output logic testModeActive,
  output logic [7:0] test_mode_selector,
  output logic [3:0] epHalt
);
  import ucrd_pkg::*;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  function automatic logic isDescOk(input logic [7:0] t);
    isDescOk = (t == DT_DEVICE) || (t == DT_CONFIG) || (t == DT_STRING) ||
               (t == DT_QUALIFIER) || (t == DT_OTHER_SPEED);
  endfunction

  function automatic logic isStatusEp(input logic [15:0] idx);
    isStatusEp = (idx == EP_BULK_IN) || (idx == EP_BULK_OUT) || (idx == EP_INTR_IN);
  endfunction

  ucrd_state_e state_q;
  ucrd_state_e state_d;
  logic [7:0] altSetting_q;
  logic [3:0] wordCnt_q;
  logic [3:0] wordLast_q;
  logic statsTx_q;

  wire logic [1:0] epNum = setupIndex[1:0];
  // index ep number must be 0..3; direction bit ignored for halt features
  wire logic epOk = (setupIndex & ~16'h0080) <= EP_MAX_NUM;
  wire logic macHit = setupIndex[11:0] >= macSpaceBase;
  wire logic idxAddrOk = setupIndex[15:12] == IDX_UPPER_ZERO;
  wire logic idle = state_q == UCRD_IDLE;

  // RL1 clear feature
  wire logic clrWake = setupType == RT_STD_DEV_OUT && setupRequest == RQ_CLR_FEATURE &&
                       setupValue == FS_REMOTE_WAKE && setupLength == LEN_ZERO;
  // RL2 endpoint index
  wire logic clrHalt = setupType == RT_STD_EP_OUT && setupRequest == RQ_CLR_FEATURE &&
                       setupValue == FS_EP_HALT && epOk && setupLength == LEN_ZERO;
  // RL3 get configuration
  wire logic getCfg = setupType == RT_STD_DEV_IN && setupRequest == RQ_GET_CONFIG &&
                      setupLength == LEN_ONE;
  // RL4 descriptor select
  wire logic getDescAny = setupType == RT_STD_DEV_IN && setupRequest == RQ_GET_DESC;
  wire logic getDesc = getDescAny && isDescOk(setupValue[15:8]);
  // RL6 get interface
  wire logic getIf = setupType == RT_STD_IF_IN && setupRequest == RQ_GET_IFACE &&
                     setupLength == LEN_ONE && setupIndex == LEN_ZERO;
  // RL7 device status
  wire logic getDevSt = setupType == RT_STD_DEV_IN && setupRequest == RQ_GET_STATUS &&
                        setupLength == LEN_TWO;
  // RL8 endpoint status
  wire logic getEpSt = setupType == RT_STD_EP_IN && setupRequest == RQ_GET_STATUS &&
                       setupLength == LEN_TWO && isStatusEp(setupIndex);
  // RL9 set address
  wire logic setAddr = setupType == RT_STD_DEV_OUT && setupRequest == RQ_SET_ADDRESS &&
                       setupLength == LEN_ZERO;
  // RL10 set feature
  wire logic setWake = setupType == RT_STD_DEV_OUT && setupRequest == RQ_SET_FEATURE &&
                       setupValue == FS_REMOTE_WAKE && setupLength == LEN_ZERO;
  wire logic setTest = setupType == RT_STD_DEV_OUT && setupRequest == RQ_SET_FEATURE &&
                       setupValue[7:0] == FS_TEST_MODE[7:0] && setupLength == LEN_ZERO;
  wire logic setHalt = setupType == RT_STD_EP_OUT && setupRequest == RQ_SET_FEATURE &&
                       setupValue == FS_EP_HALT && epOk && setupLength == LEN_ZERO;
  // RL11 RL12 set configuration, only value with low byte 01h or value 0000h (unconfigure) accepted
  wire logic setCfg = setupType == RT_STD_DEV_OUT && setupRequest == RQ_SET_CONFIG &&
                      setupLength == LEN_ZERO &&
                      (setupValue[7:0] == CONFIG_VALUE || setupValue == LEN_ZERO);
  // RL13 set interface
  wire logic setIf = setupType == RT_STD_IF_OUT && setupRequest == RQ_SET_IFACE &&
                     setupValue == LEN_ZERO && setupIndex == LEN_ZERO;
  // RL14 RL15 register write
  wire logic regWr = setupType == RT_VND_OUT && setupRequest == RQ_REG_WRITE &&
                     setupValue == LEN_ZERO && setupLength == LEN_WORD && idxAddrOk &&
                     !(normalPowerState && macHit);
  // RL17 register read
  wire logic regRd = setupType == RT_VND_IN && setupRequest == RQ_REG_READ &&
                     setupValue == LEN_ZERO && setupLength == LEN_WORD && idxAddrOk &&
                     !(normalPowerState && macHit);
  // RL21 statistics format
  wire logic statRx = setupType == RT_VND_IN && setupRequest == RQ_GET_STATS &&
                      setupIndex == IDX_RX_STATS && setupLength == LEN_RX_STATS;
  wire logic statTx = setupType == RT_VND_IN && setupRequest == RQ_GET_STATS &&
                      setupIndex == IDX_TX_STATS && setupLength == LEN_TX_STATS;

  wire logic noData = clrWake || clrHalt || setAddr || setWake || setTest || setHalt ||
                      setCfg || setIf;
  wire logic bytesResp = getCfg || getIf || getDevSt || getEpSt;
  wire logic take = setupValid && idle;

  // ----------------------------------------
  // answer selection
  // ----------------------------------------
  ucrd_answer_e kind;
  always_comb begin
    // RL5 RL22 refused formats
    kind = UCRD_STALL;
    if (noData) begin
      kind = UCRD_ACK_NODATA;
    end else if (bytesResp) begin
      kind = UCRD_RESP_BYTES;
    end else if (getDesc) begin
      kind = UCRD_DESC_FETCH;
    end else if (regWr) begin
      kind = UCRD_REG_WRITE;
    end else if (regRd) begin
      kind = UCRD_REG_READ;
    end else if (statRx || statTx) begin
      kind = UCRD_STATS;
    end
  end

  logic [15:0] bytesVal;
  always_comb begin
    bytesVal = 16'h0000;
    if (getCfg) begin
      // RL3 configuration value
      bytesVal = {8'h00, configured ? CONFIG_VALUE : 8'h00};
    end else if (getIf) begin
      // RL6 alternate setting
      bytesVal = {8'h00, altSetting_q};
    end else if (getDevSt) begin
      // RL7 device status bits
      bytesVal = {14'h0000, remoteWakeEnable, selfPowered};
    end else if (getEpSt) begin
      // RL8 halt bit
      bytesVal = {15'h0000, epHalt[epNum]};
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      UCRD_IDLE: begin
        if (take && kind == UCRD_REG_WRITE) begin
          state_d = UCRD_WDATA;
        end else if (take && (kind == UCRD_REG_READ || kind == UCRD_STATS)) begin
          state_d = UCRD_STREAM;
        end
      end
      UCRD_WDATA: begin
        if (outWordValid) begin
          state_d = UCRD_IDLE;
        end
      end
      UCRD_STREAM: begin
        if (inWordReady && wordCnt_q == wordLast_q) begin
          state_d = UCRD_IDLE;
        end
      end
      default: state_d = UCRD_IDLE;
    endcase
  end

  // one word from setup take of a read, or per counter in a dump
  wire logic streaming = state_q == UCRD_STREAM;
  wire logic [31:0] streamWord = answerKind == UCRD_REG_READ ? regReadData :
                                 (statsTx_q ? txStatsWord : rxStatsWord);
  assign inWordValid = streaming;
  assign inWord = streamWord;
  assign statsIndex = wordCnt_q;
  assign statsSelTx = statsTx_q;
  // RL16 single word write
  assign regWrite = state_q == UCRD_WDATA && outWordValid;
  assign regWriteData = outWord;
  assign regRead = streaming && answerKind == UCRD_REG_READ;
  wire logic statsDone = streaming && answerKind == UCRD_STATS && inWordReady &&
                         wordCnt_q == wordLast_q;
  // RL19 clear after serving in original variant
  assign statsClear = statsDone && !SnapshotVariant;
  // RL20 snapshot at start in later variant
  assign statsSnapshot = take && kind == UCRD_STATS && SnapshotVariant;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= UCRD_IDLE;
      wordCnt_q <= 4'h0;
      wordLast_q <= 4'h0;
      statsTx_q <= 1'b0;
      regAddr <= 12'h000;
    end else begin
      state_q <= state_d;
      if (take) begin
        wordCnt_q <= 4'h0;
        // RL18 whole store by index
        wordLast_q <= statTx ? 4'(TX_WORDS - 1) : (statRx ? 4'(RX_WORDS - 1) : 4'h0);
        statsTx_q <= statTx;
        regAddr <= setupIndex[11:0];
      end else if (streaming && inWordReady) begin
        wordCnt_q <= wordCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      answerValid <= 1'b0;
      answerKind <= UCRD_ACK_NODATA;
      respBytes <= 16'h0000;
      respLength <= 16'h0000;
      descFetch <= 1'b0;
      descType <= 8'h00;
      descIndex <= 8'h00;
      descLength <= 16'h0000;
    end else begin
      answerValid <= take;
      descFetch <= take && kind == UCRD_DESC_FETCH;
      if (take) begin
        answerKind <= kind;
        respBytes <= bytesVal;
        respLength <= bytesResp ? setupLength : LEN_ZERO;
        // RL4 truncated length passed on
        descType <= setupValue[15:8];
        descIndex <= setupValue[7:0];
        descLength <= setupLength;
      end
    end
  end

  // ----------------------------------------
  // device state
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      deviceAddress <= 7'h00;
      configured <= 1'b0;
      remoteWakeEnable <= 1'b0;
      testModeActive <= 1'b0;
      test_mode_selector <= 8'h00;
      altSetting_q <= 8'h00;
      epHalt <= 4'h0;
    end else if (take) begin
      // RL9 adopt address
      if (setAddr) begin
        deviceAddress <= setupValue[6:0];
      end
      // RL11 configured state
      if (setCfg) begin
        configured <= setupValue[7:0] == CONFIG_VALUE;
      end
      // RL1 RL10 remote wakeup
      if (setWake) begin
        remoteWakeEnable <= 1'b1;
      end else if (clrWake) begin
        remoteWakeEnable <= 1'b0;
      end
      // RL10 test mode
      if (setTest) begin
        testModeActive <= 1'b1;
        test_mode_selector <= setupIndex[15:8];
      end
      if (setIf) begin
        altSetting_q <= 8'h00;
      end
      // RL1 RL2 RL10 endpoint halt
      if (setHalt) begin
        epHalt[epNum] <= 1'b1;
      end else if (clrHalt) begin
        epHalt[epNum] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_stall_unmatched: assert property (@(posedge core_clk) disable iff (!rst_n) // RL22
    take && kind == UCRD_STALL |=> answerValid && answerKind == UCRD_STALL)
    else $error("unmatched setup not stalled");
  a_stall_bad_desc: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
    take && getDescAny && !isDescOk(setupValue[15:8]) |=> answerKind == UCRD_STALL && !descFetch)
    else $error("unsupported descriptor not stalled");
  a_address_taken: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
    take && setAddr |=> deviceAddress == $past(setupValue[6:0]))
    else $error("address not adopted");
  a_wake_status: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
    take && getDevSt |=> respBytes == {14'h0000, $past(remoteWakeEnable), $past(selfPowered)})
    else $error("device status wrong");
  a_halt_set: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
    take && setHalt |=> epHalt[$past(epNum)])
    else $error("halt not set");
  a_halt_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RL1
    take && clrHalt |=> !epHalt[$past(epNum)])
    else $error("halt not cleared");
  a_mac_stall: assert property (@(posedge core_clk) disable iff (!rst_n) // RL14
    take && normalPowerState && macHit && setupRequest == RQ_REG_WRITE |=> answerKind == UCRD_STALL)
    else $error("mac access not stalled");
  a_single_write: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
    regWrite |=> !regWrite && state_q == UCRD_IDLE)
    else $error("write burst seen");
  a_config_set: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
    take && setCfg && setupValue[7:0] == CONFIG_VALUE |=> configured)
    else $error("not configured");
  a_iface_ack: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
    take && setupType == RT_STD_IF_OUT && setupRequest == RQ_SET_IFACE && setupValue != LEN_ZERO
    |=> answerKind == UCRD_STALL)
    else $error("bad set interface acked");
endmodule

// ==== verif/ucrd_host_model.sv ====
// host side model: accepts streamed words with stalls, serves data sources
// assumes the bench drives setup fields and write data itself
`timescale 1ns/1ns
module ucrd_host_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [11:0] regAddr,
  input wire logic [3:0] statsIndex,
  output logic inWordReady,
  output logic [31:0] regReadData,
  output logic [31:0] rxStatsWord,
  output logic [31:0] txStatsWord
);
  logic [7:0] lfsr_q;
  // ----------------------------------------
  // data sources
  // ----------------------------------------
  // one addressed word
  assign regReadData = {16'ha500, 4'h0, regAddr};
  assign rxStatsWord = {8'h3c, 20'h0, statsIndex};
  assign txStatsWord = {8'h7e, 20'h0, statsIndex};
  // ----------------------------------------
  // acceptance pacing
  // ----------------------------------------
  // a pseudo random stall keeps the stream from relying on a ready that never drops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= 8'h01;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end
  assign inWordReady = slow ? lfsr_q[0] : 1'b1;
endmodule

// ==== verif/usb_control_request_decoder_tb.sv ====
// self-checking bench for the control request decoder
// assumes the snapshot variant and a mac space starting at 800h
`timescale 1ns/1ns
module usb_control_request_decoder_tb;
  import ucrd_pkg::*;
  logic core_clk, rst_n, setupValid, selfPowered, normalPowerState, outWordValid, inWordReady, slow;
  logic answerValid, descFetch, regWrite, regRead, inWordValid, statsSelTx, statsClear, statsSnapshot;
  logic configured, remoteWakeEnable, testModeActive, snapQ;
  logic [7:0] setupType, setupRequest, descType, descIndex, test_mode_selector;
  logic [15:0] setupValue, setupIndex, setupLength, respBytes, respLength, descLength;
  logic [31:0] outWord, regReadData, rxStatsWord, txStatsWord, regWriteData, inWord, r;
  logic [11:0] regAddr;
  logic [3:0] statsIndex, epHalt;
  logic [6:0] deviceAddress;
  ucrd_answer_e answerKind;
  int error_cnt, cmp_count, cyc, seed;
  logic [31:0] expQ [$];
  logic [15:0] epIdx [3] = '{EP_BULK_IN, EP_BULK_OUT, EP_INTR_IN};
  logic [7:0] dts [7] = '{DT_DEVICE, DT_CONFIG, DT_STRING, DT_QUALIFIER, DT_OTHER_SPEED, 8'h04, 8'h05};

  ucrd_decoder dut (.core_clk(core_clk), .rst_n(rst_n), .setupValid(setupValid), .setupType(setupType),
    .setupRequest(setupRequest), .setupValue(setupValue), .setupIndex(setupIndex), .setupLength(setupLength),
    .selfPowered(selfPowered), .normalPowerState(normalPowerState), .macSpaceBase(12'h800),
    .outWordValid(outWordValid), .outWord(outWord), .inWordReady(inWordReady), .regReadData(regReadData),
    .rxStatsWord(rxStatsWord), .txStatsWord(txStatsWord), .answerValid(answerValid), .answerKind(answerKind),
    .respBytes(respBytes), .respLength(respLength), .descFetch(descFetch), .descType(descType),
    .descIndex(descIndex), .descLength(descLength), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWriteData(regWriteData), .inWordValid(inWordValid), .inWord(inWord), .statsIndex(statsIndex),
    .statsSelTx(statsSelTx), .statsClear(statsClear), .statsSnapshot(statsSnapshot),
    .deviceAddress(deviceAddress), .configured(configured), .remoteWakeEnable(remoteWakeEnable),
    .testModeActive(testModeActive), .test_mode_selector(test_mode_selector), .epHalt(epHalt));
  ucrd_host_model host (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .regAddr(regAddr),
    .statsIndex(statsIndex), .inWordReady(inWordReady), .regReadData(regReadData),
    .rxStatsWord(rxStatsWord), .txStatsWord(txStatsWord));
  // ----------------------------------------
  // expectations and shared tasks
  // ----------------------------------------
  function automatic logic [31:0] statW(input bit tx, input int k);
    return {tx ? 8'h7e : 8'h3c, 20'h0, k[3:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic req(input logic [7:0] t, q, input logic [15:0] v, x, n, input ucrd_answer_e k, input string nm);
    @(posedge core_clk);
    setupValid <= 1'b1;
    {setupType, setupRequest, setupValue, setupIndex, setupLength} <= {t, q, v, x, n};
    #1 snapQ = statsSnapshot;
    @(posedge core_clk);
    setupValid <= 1'b0;
    #1 chk({nm, " answer"}, answerValid, 1);
    chk({nm, " kind"}, answerKind, k);
  endtask
  // waits for the stream to drain; a limit keeps a stuck stream from hanging the run
  task automatic drain();
    repeat (400) begin
      if (expQ.size() == 0) break;
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
    chk("words left", expQ.size(), 0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    req(RT_VND_OUT, RQ_REG_WRITE, 16'h0, {4'h0, a}, LEN_WORD, UCRD_REG_WRITE, "reg write");
    @(posedge core_clk);
    outWordValid <= 1'b1;
    outWord <= d;
    #1 chk("write strobe", regWrite, 1);
    chk("write addr", regAddr, a);
    chk("write data", regWriteData, d);
    @(posedge core_clk);
    #1 chk("no burst", regWrite, 0);
    @(posedge core_clk);
    outWordValid <= 1'b0;
  endtask
  task automatic stats(input bit tx);
    for (int k = 0; k < (tx ? LEN_TX_STATS : LEN_RX_STATS) / 4; k++) expQ.push_back(statW(tx, k));
    req(RT_VND_IN, RQ_GET_STATS, 16'h0, {15'h0, tx}, tx ? LEN_TX_STATS : LEN_RX_STATS, UCRD_STATS, "stats");
    chk("snapshot", snapQ, 1);
    chk("stats select", statsSelTx, tx);
    drain();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // monitors and clock
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (inWordValid === 1'b1 && inWordReady === 1'b1) begin
      chk("stream word", inWord, expQ.size() > 0 ? expQ.pop_front() : 32'hx);
    end
    if (rst_n === 1'b1 && statsClear !== 1'b0) chk("stats clear", statsClear, 0);
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h1ca7abc8;
    {rst_n, setupValid, outWordValid, slow, normalPowerState, selfPowered} = 6'h0;
    {setupType, setupRequest, setupValue, setupIndex, setupLength, outWord} = '0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    r = $random(seed);
    selfPowered <= r[0];
    req(RT_STD_DEV_IN, RQ_GET_STATUS, 16'h0, 16'h0, LEN_TWO, UCRD_RESP_BYTES, "dev status");
    chk("status bytes", respBytes, {15'h0, r[0]});
    chk("status length", respLength, LEN_TWO);
    req(RT_STD_DEV_OUT, RQ_SET_FEATURE, FS_REMOTE_WAKE, 16'h0, LEN_ZERO, UCRD_ACK_NODATA, "wake on");
    req(RT_STD_DEV_IN, RQ_GET_STATUS, 16'h0, 16'h0, LEN_TWO, UCRD_RESP_BYTES, "dev status");
    chk("status wake", respBytes, {14'h0, 1'b1, r[0]});
    req(RT_STD_DEV_OUT, RQ_CLR_FEATURE, FS_REMOTE_WAKE, 16'h0, LEN_ZERO, UCRD_ACK_NODATA, "wake off");
    chk("wake cleared", remoteWakeEnable, 0);
    $display("status and wakeup done");
    for (int e = 0; e < 3; e++) begin
      req(RT_STD_EP_OUT, RQ_SET_FEATURE, FS_EP_HALT, epIdx[e], LEN_ZERO, UCRD_ACK_NODATA, "halt on");
      chk("halt set", epHalt, 32'h1 << (e + 1));
      req(RT_STD_EP_IN, RQ_GET_STATUS, 16'h0, epIdx[e], LEN_TWO, UCRD_RESP_BYTES, "ep status");
      chk("ep status", respBytes, 1);
      req(RT_STD_EP_OUT, RQ_CLR_FEATURE, FS_EP_HALT, epIdx[e], LEN_ZERO, UCRD_ACK_NODATA, "halt off");
      chk("halt cleared", epHalt, 0);
    end
    $display("endpoint halt done");
    r = $random(seed);
    req(RT_STD_DEV_OUT, RQ_SET_ADDRESS, {9'h0, r[6:0]}, 16'h0, LEN_ZERO, UCRD_ACK_NODATA, "address");
    chk("address", deviceAddress, r[6:0]);
    req(RT_STD_DEV_OUT, RQ_SET_CONFIG, 16'h0001, 16'h0, LEN_ZERO, UCRD_ACK_NODATA, "set config");
    chk("configured", configured, 1);
    req(RT_STD_DEV_IN, RQ_GET_CONFIG, 16'h0, 16'h0, LEN_ONE, UCRD_RESP_BYTES, "get config");
    chk("config byte", respBytes, CONFIG_VALUE);
    req(RT_STD_DEV_OUT, RQ_SET_CONFIG, 16'h0005, 16'h0, LEN_ZERO, UCRD_STALL, "bad config");
    req(RT_STD_IF_OUT, RQ_SET_IFACE, 16'h0, 16'h0, LEN_ZERO, UCRD_ACK_NODATA, "set iface");
    req(RT_STD_IF_OUT, RQ_SET_IFACE, 16'h0001, 16'h0, LEN_ZERO, UCRD_STALL, "alt one");
    req(RT_STD_IF_OUT, RQ_SET_IFACE, 16'h0, 16'h0001, LEN_ZERO, UCRD_STALL, "iface one");
    req(RT_STD_IF_IN, RQ_GET_IFACE, 16'h0, 16'h0, LEN_ONE, UCRD_RESP_BYTES, "get iface");
    chk("alt setting", respBytes, 0);
    $display("address config interface done");
    for (int i = 0; i < 7; i++) begin
      r = $random(seed);
      req(RT_STD_DEV_IN, RQ_GET_DESC, {dts[i], r[7:0]}, 16'h0, {8'h0, r[15:8]},
        i < 5 ? UCRD_DESC_FETCH : UCRD_STALL, "get desc");
      chk("desc fetch", descFetch, i < 5);
      if (i < 5) begin
        chk("desc type", {descType, descIndex}, {dts[i], r[7:0]});
        chk("desc length", descLength, r[15:8]);
      end
    end
    $display("descriptors done");
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      slow <= r[31];
      wr(r[10:0], $random(seed));
      expQ.push_back({16'ha500, 5'h0, r[10:0]});
      req(RT_VND_IN, RQ_REG_READ, 16'h0, {5'h0, r[10:0]}, LEN_WORD, UCRD_REG_READ, "reg read");
      chk("read strobe", regRead, 1);
      drain();
    end
    normalPowerState <= 1'b1;
    req(RT_VND_OUT, RQ_REG_WRITE, 16'h0, 16'h0900, LEN_WORD, UCRD_STALL, "mac write");
    req(RT_VND_IN, RQ_REG_READ, 16'h0, 16'h0a04, LEN_WORD, UCRD_STALL, "mac read");
    normalPowerState <= 1'b0;
    wr(12'h900, 32'h5a5a_0f0f);
    $display("register access done");
    slow <= 1'b1;
    stats(1'b0);
    stats(1'b1);
    $display("statistics done");
    req(RT_STD_DEV_OUT, RQ_SET_FEATURE, FS_TEST_MODE, 16'h0400, LEN_ZERO, UCRD_ACK_NODATA, "test mode");
    chk("test mode", {testModeActive, test_mode_selector}, 9'h104);
    req(8'h20, RQ_CLR_FEATURE, 16'h0, 16'h0, LEN_ZERO, UCRD_STALL, "class req");
    req(RT_VND_IN, 8'ha7, 16'h0, 16'h0, LEN_WORD, UCRD_STALL, "odd vendor");
    $display("test mode and unmatched done");
    results();
  end
endmodule
